// [include/cbpc_cfg.svh]
`ifndef CBPC_CFG_SVH
`define CBPC_CFG_SVH
// bus widths
`define CBPC_ADDR_W 23
`define CBPC_DATA_W 16
// synchronised pin bundle: acknowledge, fault, halt, data
`define CBPC_SYNC_W (3 + `CBPC_DATA_W)
// bus state numbers, one system clock per bus state
`define CBPC_ST_AS 4'h2
`define CBPC_ST_WDRV 4'h3
`define CBPC_ST_ACK 4'h4
`define CBPC_ST_LATCH 4'h6
`define CBPC_ST_END 4'h7
`define CBPC_ST_FEND 4'h9
// function code classes
`define CBPC_FC_UDATA 3'h1
`define CBPC_FC_UPROG 3'h2
`define CBPC_FC_SDATA 3'h5
`define CBPC_FC_SPROG 3'h6
`define CBPC_FC_IACK 3'h7
// status bit reset values
`define CBPC_SR_S_RST 1'b1
`define CBPC_SR_T_RST 1'b0
`endif

// [include/cbpc_pkg.sv]
package cbpc_pkg;
`include "cbpc_cfg.svh"
    // processing state of the core
    typedef enum logic [1:0] {PROC_NORMAL, PROC_EXCEPTION, PROC_HALTED} cbpc_proc_t;
    // instruction kinds the engine reports; all but plain are privileged
    typedef enum logic [2:0] {INSTR_PLAIN, INSTR_STOP, INSTR_RESET, INSTR_SR_WRITE, INSTR_USP_MOVE} cbpc_instr_t;
    // bus sequencer phase
    typedef enum logic [1:0] {BUS_IDLE, BUS_RUN, BUS_RERUN} cbpc_bus_t;
    // state of the core module apart from sp_super_ff and the synchroniser stages
    typedef struct packed {
        cbpc_proc_t proc;
        logic stopped;
        logic sbit;
        logic tbit;
        logic [1:0] saved;
        logic bflt;
        cbpc_bus_t bus;
        logic [3:0] step;
        logic write;
        logic prog;
        logic iack;
        logic [1:0] lanes;
        logic [`CBPC_ADDR_W-1:0] addr;
        logic [`CBPC_DATA_W-1:0] wdata;
        logic [`CBPC_DATA_W-1:0] rdata;
        logic fault_seen;
        logic acked;
        logic rerun;
        logic done;
        logic fault;
        logic pviol;
        logic bexc;
        logic ready;
        logic as_n;
        logic uds_n;
        logic lds_n;
        logic oe_n;
        logic [2:0] fc;
    } cbpc_state_t;
endpackage : cbpc_pkg

// [include/cbpc_sync_if.sv]
`timescale 1ns/1ps
// raw pin levels in, two-stage synchronised copy out
interface cbpc_sync_if #(parameter int W = 1);
    logic [W-1:0] raw; // pin side, asynchronous
    logic [W-1:0] sync; // clock domain side
    modport pin (output raw, input sync);
    modport sync_side (input raw, output sync);
endinterface : cbpc_sync_if

// [rtl/cbpc_sync.sv]
`timescale 1ns/1ps
module cbpc_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    cbpc_sync_if.sync_side port
);
    // both stages in one state word
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } cbpc_sync_state_t;

    cbpc_sync_state_t st_ff; // registered stages
    cbpc_sync_state_t nxt_st; // next stages

    // refuse widths the bundle cannot carry
    if (W < 1 || $bits(port.raw) != W)
    begin : g_bad_width
        $error("synchroniser width does not match bundle");
    end

    // first stage feeds only the second; resets to negated (high) levels
    always_comb
    begin
        nxt_st.s1 = port.raw;
        nxt_st.s2 = st_ff.s1;
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            st_ff <= '1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign port.sync = st_ff.s2;
endmodule : cbpc_sync

// [rtl/cbpc_core.sv]
`timescale 1ns/1ps
`include "cbpc_cfg.svh"
// one system clock is one bus state; the end of each even state
// stands for the bus clock falling edge where inputs are sampled
module cbpc_core (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic req_prog_in,
    input wire logic req_iack_in,
    input wire logic [1:0] req_lanes_in,
    input wire logic [`CBPC_ADDR_W-1:0] req_addr_in,
    input wire logic [`CBPC_DATA_W-1:0] req_wdata_in,
    output logic req_ready_out,
    output logic done_out,
    output logic fault_out,
    output logic [`CBPC_DATA_W-1:0] rdata_out,
    input wire logic instr_valid_in,
    input wire cbpc_pkg::cbpc_instr_t instr_kind_in,
    input wire logic [1:0] sr_wdata_in,
    input wire logic exc_req_in,
    input wire logic exc_done_in,
    output cbpc_pkg::cbpc_proc_t proc_state_out,
    output logic stopped_out,
    output logic privilege_out,
    output logic trace_en_out,
    output logic [1:0] saved_sr_out,
    output logic priv_viol_out,
    output logic bus_fault_exc_out,
    output logic [`CBPC_ADDR_W-1:0] addr_out,
    output logic [2:0] function_code_out,
    output logic read_out,
    output logic address_strobe_n_out,
    output logic upper_byte_strobe_n_out,
    output logic lower_byte_strobe_n_out,
    output logic [`CBPC_DATA_W-1:0] data_out,
    output logic data_oe_n_out,
    input wire logic [`CBPC_DATA_W-1:0] data_in,
    input wire logic transfer_ack_n_in,
    input wire logic bus_fault_n_in,
    input wire logic halt_n_in
);
    import cbpc_pkg::*;

    // reset image: strobes negated, supervisor set, trace clear
    localparam cbpc_state_t ST_RST = '{proc: PROC_NORMAL, bus: BUS_IDLE, sbit: `CBPC_SR_S_RST,
        tbit: `CBPC_SR_T_RST, as_n: 1'b1, uds_n: 1'b1, lds_n: 1'b1, oe_n: 1'b1, default: '0};

    cbpc_state_t st_ff; // core state apart from sp_super_ff and the synchroniser
    cbpc_state_t nxt_st; // its next value
    logic ack_a; // acknowledge recognized
    logic fault_a; // bus fault recognized
    logic halt_a; // halt recognized
    logic [`CBPC_DATA_W-1:0] data_s; // synchronised read data
    logic fin; // bus cycle terminates this cycle
    logic priv; // reported instruction is privileged

    // pins pass two flops; data shares the latency of acknowledge
    cbpc_sync_if #(.W(`CBPC_SYNC_W)) pin_if ();
    assign pin_if.raw = {transfer_ack_n_in, bus_fault_n_in, halt_n_in, data_in};

    cbpc_sync #(.W(`CBPC_SYNC_W)) u_sync (
        .sys_clk_in(sys_clk_in),
        .arst_n_in(arst_n_in),
        .port(pin_if)
    );

    assign ack_a = ~pin_if.sync[`CBPC_SYNC_W-1];
    assign fault_a = ~pin_if.sync[`CBPC_SYNC_W-2];
    assign halt_a = ~pin_if.sync[`CBPC_SYNC_W-3];
    assign data_s = pin_if.sync[`CBPC_DATA_W-1:0];

    // strobe levels {as_n, uds_n, lds_n, oe_n} for a given state
    function automatic logic [3:0] strobe_levels(input cbpc_state_t cur);
        logic [3:0] last;
        logic as_on;
        logic ds_on;
        logic oe_on;
        last = (cur.fault_seen && !cur.acked) ? `CBPC_ST_FEND : `CBPC_ST_END;
        as_on = (cur.bus == BUS_RUN) && (cur.step >= `CBPC_ST_AS) && (cur.step < last);
        ds_on = as_on && (!cur.write || cur.step >= `CBPC_ST_ACK);
        oe_on = (cur.bus == BUS_RUN) && cur.write && (cur.step >= `CBPC_ST_WDRV) && (cur.step < last);
        return {~as_on, ~(ds_on && cur.lanes[1]), ~(ds_on && cur.lanes[0]), ~oe_on};
    endfunction : strobe_levels

    // enter exception processing from any state but halted
    function automatic cbpc_state_t exc_enter(input cbpc_state_t cur);
        cbpc_state_t r;
        r = cur;
        // copy status, set privilege, clear trace
        r.saved = {cur.sbit, cur.tbit};
        r.sbit = 1'b1;
        r.tbit = 1'b0;
        r.proc = PROC_EXCEPTION;
        r.stopped = 1'b0;
        return r;
    endfunction : exc_enter

    // bus sequencer and processing state
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        nxt_st.fault = 1'b0;
        nxt_st.pviol = 1'b0;
        nxt_st.bexc = 1'b0;
        fin = 1'b0;
        priv = (instr_kind_in != INSTR_PLAIN);
        unique case (st_ff.bus)
            BUS_IDLE:
            begin
                // ready already excludes stopped and halted cores
                if (req_valid_in && st_ff.ready)
                begin
                    nxt_st.bus = BUS_RUN;
                    nxt_st.step = 4'h0;
                    nxt_st.write = req_write_in;
                    nxt_st.prog = req_prog_in;
                    nxt_st.iack = req_iack_in;
                    nxt_st.lanes = req_lanes_in;
                    nxt_st.addr = req_addr_in;
                    nxt_st.wdata = req_wdata_in;
                    nxt_st.fault_seen = 1'b0;
                    nxt_st.acked = 1'b0;
                    nxt_st.rerun = 1'b0;
                    // class from privilege, space and acknowledge
                    if (req_iack_in)
                    begin
                        nxt_st.fc = `CBPC_FC_IACK;
                    end
                    else if (st_ff.sbit || st_ff.proc == PROC_EXCEPTION)
                    begin
                        nxt_st.fc = req_prog_in ? `CBPC_FC_SPROG : `CBPC_FC_SDATA;
                    end
                    else
                    begin
                        nxt_st.fc = req_prog_in ? `CBPC_FC_UPROG : `CBPC_FC_UDATA;
                    end
                end
            end
            BUS_RUN:
            begin
                // fault looked at on every even state end from S2 until acknowledge
                if (st_ff.step >= `CBPC_ST_AS && !st_ff.step[0] && fault_a && !st_ff.acked)
                begin
                    nxt_st.fault_seen = 1'b1;
                    // fault together with halt asks for a rerun
                    nxt_st.rerun = halt_a;
                end
                case (st_ff.step)
                    `CBPC_ST_ACK:
                    begin
                        // acknowledge recognized at end of S4 or a wait
                        if (ack_a)
                        begin
                            nxt_st.acked = 1'b1;
                            nxt_st.step = st_ff.step + 4'h1;
                        end
                        else if (st_ff.fault_seen || fault_a)
                        begin
                            nxt_st.step = st_ff.step + 4'h1;
                        end
                        else
                        begin
                            // one clock of wait, no limit on how many
                            nxt_st.step = `CBPC_ST_WDRV;
                        end
                    end
                    `CBPC_ST_LATCH:
                    begin
                        // read data taken one falling edge after acknowledge
                        if (!st_ff.write && st_ff.acked)
                        begin
                            nxt_st.rdata = data_s;
                        end
                        nxt_st.step = st_ff.step + 4'h1;
                    end
                    `CBPC_ST_END:
                    begin
                        // fault without acknowledge runs on to S9
                        if (st_ff.fault_seen && !st_ff.acked)
                        begin
                            nxt_st.step = st_ff.step + 4'h1;
                        end
                        else
                        begin
                            fin = 1'b1;
                        end
                    end
                    `CBPC_ST_FEND:
                    begin
                        fin = 1'b1;
                    end
                    default:
                    begin
                        nxt_st.step = st_ff.step + 4'h1;
                    end
                endcase
                if (fin)
                begin
                    nxt_st.step = 4'h0;
                    nxt_st.bus = (st_ff.fault_seen && st_ff.rerun) ? BUS_RERUN : BUS_IDLE;
                    nxt_st.done = !st_ff.fault_seen;
                    nxt_st.fault = st_ff.fault_seen && !st_ff.rerun;
                end
            end
            BUS_RERUN:
            begin
                // rerun the same access once halt is released
                if (!halt_a)
                begin
                    nxt_st.bus = BUS_RUN;
                    nxt_st.fault_seen = 1'b0;
                    nxt_st.acked = 1'b0;
                    nxt_st.rerun = 1'b0;
                end
            end
            default:
            begin
                nxt_st.bus = BUS_IDLE;
            end
        endcase

        if (st_ff.proc != PROC_HALTED)
        begin
            if (fin && st_ff.fault_seen && !st_ff.rerun)
            begin
                // second fault inside bus-fault handling halts
                if (st_ff.proc == PROC_EXCEPTION && st_ff.bflt)
                begin
                    nxt_st.proc = PROC_HALTED;
                end
                else
                begin
                    nxt_st = exc_enter(nxt_st);
                    nxt_st.bflt = 1'b1;
                    nxt_st.bexc = 1'b1;
                end
            end
            else if (instr_valid_in && st_ff.proc == PROC_NORMAL && !st_ff.stopped)
            begin
                // privileged work in user state traps instead
                if (priv && !st_ff.sbit)
                begin
                    nxt_st = exc_enter(nxt_st);
                    nxt_st.pviol = 1'b1;
                end
                // stop parks the core without a bus reference
                else if (instr_kind_in == INSTR_STOP)
                begin
                    nxt_st.stopped = 1'b1;
                end
                else if (instr_kind_in == INSTR_SR_WRITE)
                begin
                    nxt_st.sbit = sr_wdata_in[1];
                    nxt_st.tbit = sr_wdata_in[0];
                end
            end
            else if (exc_req_in && st_ff.proc == PROC_NORMAL)
            begin
                // an interrupt also wakes a stopped core
                nxt_st = exc_enter(nxt_st);
            end
            else if (exc_done_in && st_ff.proc == PROC_EXCEPTION)
            begin
                nxt_st.proc = PROC_NORMAL;
                nxt_st.sbit = sr_wdata_in[1];
                nxt_st.tbit = sr_wdata_in[0];
                nxt_st.bflt = 1'b0;
            end
        end

        // outputs are computed from the next state so they leave a flop
        // no new request while stopped or halted
        nxt_st.ready = (nxt_st.bus == BUS_IDLE) && !nxt_st.stopped && (nxt_st.proc != PROC_HALTED) && !halt_a;
        {nxt_st.as_n, nxt_st.uds_n, nxt_st.lds_n, nxt_st.oe_n} = strobe_levels(nxt_st);
    end

    // main state register; sp_super_ff has its own below
    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            st_ff <= ST_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // port map straight from the state flops
    assign req_ready_out = st_ff.ready;
    assign done_out = st_ff.done;
    assign fault_out = st_ff.fault;
    assign rdata_out = st_ff.rdata;
    assign proc_state_out = st_ff.proc;
    assign stopped_out = st_ff.stopped;
    assign privilege_out = st_ff.sbit;
    assign trace_en_out = st_ff.tbit;
    assign saved_sr_out = st_ff.saved;
    assign priv_viol_out = st_ff.pviol;
    assign bus_fault_exc_out = st_ff.bexc;
    assign addr_out = st_ff.addr;
    assign function_code_out = st_ff.fc;
    assign read_out = ~st_ff.write;
    assign address_strobe_n_out = st_ff.as_n;
    assign upper_byte_strobe_n_out = st_ff.uds_n;
    assign lower_byte_strobe_n_out = st_ff.lds_n;
    assign data_out = st_ff.wdata;
    assign data_oe_n_out = st_ff.oe_n;

    // stack pointer choice is a core-internal select; exposed as a flop
    // supervisor stack in supervisor state and exceptions
    logic sp_super_ff;
    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            sp_super_ff <= `CBPC_SR_S_RST;
        end
        else
        begin
            sp_super_ff <= nxt_st.sbit || (nxt_st.proc == PROC_EXCEPTION);
        end
    end

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    a_strobe_open: assert property (
        (st_ff.bus == BUS_RUN && st_ff.step == 4'h2) |-> !address_strobe_n_out)
        else $error("address strobe not low in S2");
    a_wait_loop: assert property (
        (st_ff.bus == BUS_RUN && st_ff.step == 4'h4 && !ack_a && !fault_a && !st_ff.fault_seen)
        |=> (st_ff.step == 4'h3) ##1 (st_ff.step == 4'h4))
        else $error("wait cycle not one clock");
    a_ack_seen: assert property (
        (st_ff.bus == BUS_RUN && st_ff.step == 4'h4 && ack_a) |=> (st_ff.step == 4'h5 && st_ff.acked))
        else $error("acknowledge not recognized");
    a_read_capture: assert property (
        (st_ff.bus == BUS_RUN && st_ff.step == 4'h6 && !st_ff.write && st_ff.acked)
        |=> (rdata_out == $past(data_s)))
        else $error("read data not captured at S6");
    a_four_clocks: assert property (
        (st_ff.bus == BUS_RUN && st_ff.step == 4'h4 && ack_a && !fault_a && !st_ff.fault_seen)
        |=> ##2 (st_ff.step == 4'h7) ##1 (st_ff.bus == BUS_IDLE && done_out))
        else $error("zero wait cycle not eight states");
    a_fault_sample: assert property (
        (st_ff.bus == BUS_RUN && st_ff.step == 4'h2 && fault_a) |=> st_ff.fault_seen)
        else $error("fault not sampled in S2");
    a_fault_tail: assert property (
        (st_ff.bus == BUS_RUN && st_ff.step == 4'h7 && st_ff.fault_seen && !st_ff.acked)
        |=> (st_ff.step == 4'h8 && !address_strobe_n_out) ##1 (st_ff.step == 4'h9 && address_strobe_n_out))
        else $error("fault termination not at S9");
    a_halt_stop_apart: assert property (
        !(st_ff.proc == PROC_HALTED && st_ff.stopped))
        else $error("stopped and halted together");
    a_halt_sticky: assert property (
        (st_ff.proc == PROC_HALTED) |=> (st_ff.proc == PROC_HALTED && !req_ready_out))
        else $error("left halted without reset");
    a_user_trap: assert property (
        (instr_valid_in && instr_kind_in != INSTR_PLAIN && !st_ff.sbit && st_ff.proc == PROC_NORMAL
        && !st_ff.stopped && !(st_ff.bus == BUS_RUN && st_ff.fault_seen))
        |=> (priv_viol_out && proc_state_out == PROC_EXCEPTION && !stopped_out))
        else $error("privileged instruction not trapped");
    a_exc_entry: assert property (
        $rose(st_ff.proc == PROC_EXCEPTION) |-> (privilege_out && !trace_en_out))
        else $error("exception entry status wrong");
    a_fc_super: assert property (
        (st_ff.bus == BUS_RUN && !st_ff.iack && st_ff.step == 4'h0 && $past(st_ff.proc) == PROC_EXCEPTION)
        |-> function_code_out[2])
        else $error("exception cycle not supervisor");
    a_sp_follow: assert property (
        ##1 (sp_super_ff == (st_ff.sbit || st_ff.proc == PROC_EXCEPTION)))
        else $error("stack pointer choice wrong");
endmodule : cbpc_core

// [tb/cbpc_slave.sv]
`timescale 1ns/1ps
// memory slave on the far side of the bus pins
module cbpc_slave (
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic as_n_in,
    input wire logic rd_in,
    input wire logic [22:0] addr_in,
    input wire logic [3:0] wait_in,
    input wire logic fault_in,
    output logic ack_n_out,
    output logic flt_n_out,
    output logic [15:0] data_out
);
    logic [3:0] cnt_ff; // clocks since strobe fell
    // answers on rising edges so acknowledge and fault set up together
    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cnt_ff <= 4'h0;
            ack_n_out <= 1'b1;
            flt_n_out <= 1'b1;
            data_out <= 16'h0000;
        end
        else
        begin
            if (as_n_in)
            begin
                cnt_ff <= 4'h0;
                ack_n_out <= 1'b1;
                flt_n_out <= 1'b1;
            end
            else
            begin
                cnt_ff <= cnt_ff + {3'h0, cnt_ff != 4'hF};
                ack_n_out <= fault_in | (cnt_ff < wait_in);
                flt_n_out <= !fault_in;
            end
            // data toggles when not read, so stale values never match
            data_out <= (!as_n_in && rd_in) ? (addr_in[15:0] ^ 16'hA5C3) : ~data_out;
        end
    end
endmodule : cbpc_slave

// [tb/tb_top.sv]
`timescale 1ns/1ps
`include "cbpc_cfg.svh"
// drives the core at falling edges and compares with a small model
module tb_top;
    import cbpc_pkg::*;
    logic sys_clk_in, arst_n_in, req_valid_in, req_write_in, req_prog_in, req_iack_in;
    logic req_ready_out, done_out, fault_out, instr_valid_in, exc_req_in, exc_done_in;
    logic stopped_out, privilege_out, trace_en_out, priv_viol_out, bus_fault_exc_out, read_out;
    logic address_strobe_n_out, upper_byte_strobe_n_out, lower_byte_strobe_n_out, data_oe_n_out;
    logic transfer_ack_n_in, bus_fault_n_in, halt_n_in, flt;
    logic [1:0] req_lanes_in, sr_wdata_in, saved_sr_out;
    logic [2:0] function_code_out;
    logic [3:0] wt; // slave wait clocks
    logic [`CBPC_ADDR_W-1:0] req_addr_in, addr_out;
    logic [`CBPC_DATA_W-1:0] req_wdata_in, rdata_out, data_out, data_in;
    logic [31:0] sd = 32'h3F1A; // xorshift state
    cbpc_instr_t instr_kind_in;
    cbpc_proc_t proc_state_out;
    int error_cnt, cmp_count, ms, mt, mp, st; // model: S, T, processing state, stopped
    cbpc_core dut (.sys_clk_in, .arst_n_in, .req_valid_in, .req_write_in, .req_prog_in,
        .req_iack_in, .req_lanes_in, .req_addr_in, .req_wdata_in, .req_ready_out, .done_out,
        .fault_out, .rdata_out, .instr_valid_in, .instr_kind_in, .sr_wdata_in, .exc_req_in,
        .exc_done_in, .proc_state_out, .stopped_out, .privilege_out, .trace_en_out, .saved_sr_out,
        .priv_viol_out, .bus_fault_exc_out, .addr_out, .function_code_out, .read_out,
        .address_strobe_n_out, .upper_byte_strobe_n_out, .lower_byte_strobe_n_out, .data_out,
        .data_oe_n_out, .data_in, .transfer_ack_n_in, .bus_fault_n_in, .halt_n_in);
    cbpc_slave slv (.sys_clk_in, .arst_n_in, .as_n_in(address_strobe_n_out), .rd_in(read_out),
        .addr_in(addr_out), .wait_in(wt), .fault_in(flt), .ack_n_out(transfer_ack_n_in),
        .flt_n_out(bus_fault_n_in), .data_out(data_in));
    // free running clock, 8 ns
    initial
    begin
        sys_clk_in = 1'b0;
        forever #4 sys_clk_in = ~sys_clk_in;
    end
    function automatic logic [31:0] rnd();
        sd ^= sd << 13;
        sd ^= sd >> 17;
        sd ^= sd << 5;
        return sd;
    endfunction : rnd
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("mismatches %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic state();
        chk("proc", proc_state_out, mp);
        chk("priv", privilege_out, ms);
        chk("trace", trace_en_out, mt);
        chk("stopped", stopped_out, st);
    endtask : state
    // one bus cycle; f makes the slave answer with a fault
    task automatic bus(input logic w, p, ia, f);
        logic [1:0] ds;
        logic [2:0] fc;
        logic [15:0] wd;
        logic bx;
        int lat;
        ds = 2'h0;
        bx = 1'b0;
        lat = 0;
        wt = 4'(rnd() % 7);
        flt = f;
        req_write_in = w;
        req_prog_in = p;
        req_iack_in = ia;
        req_lanes_in = 2'(rnd() % 3 + 1);
        req_addr_in = 23'(rnd());
        req_wdata_in = 16'(rnd());
        fc = ia ? 3'h7 : {1'(ms | (mp == 1)), p, !p};
        while (req_ready_out !== 1'b1 && lat < 50)
        begin
            @(negedge sys_clk_in);
            lat++;
        end
        req_valid_in = 1'b1;
        @(negedge sys_clk_in);
        req_valid_in = 1'b0;
        lat = 1;
        while ((done_out | fault_out) !== 1'b1 && lat < 300)
        begin
            if (!address_strobe_n_out)
                chk("fcode", function_code_out, fc);
            ds |= ~{upper_byte_strobe_n_out, lower_byte_strobe_n_out};
            if (!data_oe_n_out)
                wd = data_out;
            bx |= bus_fault_exc_out;
            @(negedge sys_clk_in);
            lat++;
        end
        chk("done", done_out, !f);
        chk("fault", fault_out, f);
        if (!f)
        begin
            chk("addr", addr_out, req_addr_in);
            chk("read", read_out, !w);
            chk("latency", lat >= ((wt > 1) ? 7 + wt : 9), 1'b1);
            chk("strobes", ds, req_lanes_in);
            chk("data", w ? wd : rdata_out, w ? req_wdata_in : req_addr_in[15:0] ^ 16'hA5C3);
        end
        repeat (3)
        begin
            bx |= bus_fault_exc_out;
            @(negedge sys_clk_in);
        end
        chk("bus_exc", bx, f && mp == 0);
        if (f && mp == 0)
        begin
            chk("saved", saved_sr_out, {ms[0], mt[0]});
            {ms, mt} = {32'd1, 32'd0};
        end
        if (f)
            mp = (mp == 0) ? 1 : 2;
        chk("proc", proc_state_out, mp);
    endtask : bus
    task automatic ins(input cbpc_instr_t k);
        int v;
        v = (ms == 0 && k != INSTR_PLAIN);
        instr_kind_in = k;
        instr_valid_in = 1'b1;
        @(negedge sys_clk_in);
        instr_valid_in = 1'b0;
        chk("violation", priv_viol_out, v);
        if (v)
        begin
            chk("saved", saved_sr_out, {ms[0], mt[0]});
            {ms, mt, mp} = {32'd1, 32'd0, 32'd1};
        end
        else if (k == INSTR_STOP)
            st = 1;
        state();
    endtask : ins
    // r high requests an exception, low ends one restoring sr
    task automatic exc(input logic r, input logic [1:0] sr);
        sr_wdata_in = sr;
        exc_req_in = r;
        exc_done_in = !r;
        @(negedge sys_clk_in);
        exc_req_in = 1'b0;
        exc_done_in = 1'b0;
        if (r && mp == 0)
        begin
            chk("saved", saved_sr_out, {ms[0], mt[0]});
            {ms, mt, mp, st} = {32'd1, 32'd0, 32'd1, 32'd0};
        end
        else if (!r && mp == 1)
            {mp, ms, mt} = {32'd0, 31'd0, sr[1], 31'd0, sr[0]};
        state();
    endtask : exc
    // hang guard, far beyond the expected run
    initial
    begin
        #500000;
        error_cnt++;
        report_and_stop();
    end
    initial
    begin
        {arst_n_in, req_valid_in, req_write_in, req_prog_in, req_iack_in, flt} = 6'h00;
        {instr_valid_in, exc_req_in, exc_done_in, req_lanes_in, sr_wdata_in} = 7'h00;
        {req_addr_in, req_wdata_in, wt} = 43'h0;
        instr_kind_in = INSTR_PLAIN;
        halt_n_in = 1'b1;
        {error_cnt, cmp_count, ms, mt, mp, st} = {32'd0, 32'd0, 32'd1, 96'd0};
        repeat (3) @(negedge sys_clk_in);
        arst_n_in = 1'b1;
        state();
        repeat (6) bus(1'(rnd()), 1'(rnd()), 1'b0, 1'b0);
        bus(1'b0, 1'b0, 1'b1, 1'b0);
        ins(INSTR_PLAIN);
        ins(INSTR_STOP);
        @(negedge sys_clk_in);
        chk("ready", req_ready_out, 1'b0);
        exc(1'b1, 2'h0);
        exc(1'b0, 2'h1);
        repeat (4) bus(1'(rnd()), 1'(rnd()), 1'b0, 1'b0);
        for (int k = 1; k < 5; k++)
        begin
            ins(cbpc_instr_t'(k));
            exc(1'b0, 2'h1);
        end
        bus(1'b0, 1'b0, 1'b0, 1'b1);
        bus(1'b1, 1'b0, 1'b0, 1'b1);
        repeat (20) @(negedge sys_clk_in);
        exc(1'b1, 2'h0);
        chk("ready", req_ready_out, 1'b0);
        arst_n_in = 1'b0;
        @(negedge sys_clk_in);
        arst_n_in = 1'b1;
        {ms, mt, mp, st} = {32'd1, 96'd0};
        state();
        bus(1'b0, 1'b1, 1'b0, 1'b0);
        // fault with halt must rerun the read, which then completes
        fork
            bus(1'b0, 1'b0, 1'b0, 1'b0);
            begin
                @(negedge address_strobe_n_out);
                @(negedge sys_clk_in);
                {flt, halt_n_in} = 2'h2;
                repeat (12) @(negedge sys_clk_in);
                {flt, halt_n_in} = 2'h1;
            end
        join
        report_and_stop();
    end
endmodule : tb_top
